// [src/vsync_pkg.sv]
package vsync_pkg;
    // integrator counter
    localparam int INTEG_WIDTH = 16;
    localparam logic [15:0] INTEG_RESET = 16'h0000;
    // charge step per clock while sync is active
    localparam logic [15:0] CHARGE_STEP_DEFAULT = 16'h0001;
    // discharge step per clock while sync is inactive
    localparam logic [15:0] DISCHARGE_STEP_DEFAULT = 16'h0004;
    // compare levels, in integrator counts
    localparam logic [15:0] SERRATION_THRESHOLD_DEFAULT = 16'h0BB8;
    localparam logic [15:0] DEFAULT_THRESHOLD_DEFAULT = 16'h1F40;
    // oscillator: eight cycles make one vertical pulse
    localparam int OSC_CYCLES = 8;
    localparam int CLK_PERIOD_NS = 8;
    // eight cycles should span about 180 us
    localparam int PULSE_TARGET_US = 180;
    localparam int PULSE_TARGET_CLKS = (PULSE_TARGET_US * 1000) / CLK_PERIOD_NS;
    localparam int OSC_HALF_DEFAULT = PULSE_TARGET_CLKS / (2 * OSC_CYCLES);
    localparam int OSC_WIDTH = 16;
    localparam int DIV_WIDTH = 4;
endpackage : vsync_pkg

// [src/vsync_osc_if.sv]
`timescale 1ns/1ps
interface vsync_osc_if;
    logic run;
    logic tick;
    modport ctrl (output run, input tick);
    modport osc (input run, output tick);
endinterface : vsync_osc_if

// [src/vsync_osc.sv]
`timescale 1ns/1ps
module vsync_osc
    import vsync_pkg::*;
#(
    parameter int HALF_PERIOD = OSC_HALF_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // control
    vsync_osc_if.osc port
);
    localparam logic [OSC_WIDTH-1:0] PERIOD_LAST = OSC_WIDTH'(2 * HALF_PERIOD - 1);

    logic [OSC_WIDTH-1:0] phase_r;
    logic [OSC_WIDTH-1:0] phase_nxt;
    logic tick_r;
    wire at_end = (phase_r == PERIOD_LAST);

    // free-running only while enabled; restarts from phase zero
    assign phase_nxt = (!port.run || at_end) ? '0 : phase_r + 1'b1;

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            phase_r <= '0;
            tick_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            tick_r <= port.run && at_end;
        end
    end

    assign port.tick = tick_r;
endmodule : vsync_osc

// [src/vsync_extractor.sv]
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - csync output copies below-black sync only
// - integrator charges only while sync active
// - normal lines, equalizing stay below threshold
// - serration falling edge samples threshold compare
// - capture ORs into latch; latch enables oscillator
// - divide by eight clears the latch
// - latch output is vertical sync output
// - integrator charge step tied to resistor parameter; oscillator period set by OSC_HALF
// - slow charge gives no vertical pulse
// - later serration may retrigger after pulse
// - size pulse to cover serrated interval
// - default threshold also sets the latch
module vsync_extractor
    import vsync_pkg::*;
#(
    parameter logic [15:0] timing_resistor_param = CHARGE_STEP_DEFAULT,
    parameter logic [15:0] DISCHARGE_STEP = DISCHARGE_STEP_DEFAULT,
    parameter logic [15:0] serration_threshold = SERRATION_THRESHOLD_DEFAULT,
    parameter logic [15:0] default_threshold = DEFAULT_THRESHOLD_DEFAULT,
    parameter int OSC_HALF = OSC_HALF_DEFAULT
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // sliced video: high when input lies below black level
    input wire logic below_black,
    // sync outputs
    output logic csync_out,
    output logic vsync_out,
    output logic field_clk_out
);
    //////////////////////////////////////////////////////////////////////////
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_PULSE = 2'b10
    } vstate_t;

    //////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic is_pulse(input vstate_t st);
        return st == ST_PULSE;
    endfunction : is_pulse

    // saturating charge: the counter must not wrap back below the thresholds
    function automatic logic [INTEG_WIDTH-1:0] sat_add(input logic [INTEG_WIDTH-1:0] a,
        input logic [INTEG_WIDTH-1:0] b);
        logic [INTEG_WIDTH:0] sum;
        sum = {1'b0, a} + {1'b0, b};
        return sum[INTEG_WIDTH] ? '1 : sum[INTEG_WIDTH-1:0];
    endfunction : sat_add

    // discharge with a floor at zero
    function automatic logic [INTEG_WIDTH-1:0] sat_sub(input logic [INTEG_WIDTH-1:0] a,
        input logic [INTEG_WIDTH-1:0] b);
        return (a < b) ? '0 : a - b;
    endfunction : sat_sub

    vstate_t state_r;
    vstate_t state_nxt;
    logic [INTEG_WIDTH-1:0] integ_r;
    logic [INTEG_WIDTH-1:0] integ_nxt;
    logic sync_d_r;
    logic capture_r;
    logic [DIV_WIDTH-1:0] div_r;
    logic [DIV_WIDTH-1:0] div_nxt;
    logic csync_r;
    logic vsync_r;
    logic field_clk_r;
    logic vsync_d_r;
    logic sync_d_nxt;
    logic capture_nxt;
    logic csync_nxt;
    logic vsync_nxt;
    logic vsync_d_nxt;
    logic field_clk_nxt;

    vsync_osc_if osc_bus ();

    //////////////////////////////////////////////////////////////////////////
    // integrator
    wire sync_active = below_black;
    wire [INTEG_WIDTH-1:0] charged = sat_add(integ_r, timing_resistor_param);
    wire [INTEG_WIDTH-1:0] drained = sat_sub(integ_r, DISCHARGE_STEP);

    // charges only while sync is active, drains otherwise
    assign integ_nxt = sync_active ? charged : drained;

    // comparators
    wire above_serr = (integ_r > serration_threshold);
    wire above_dflt = (integ_r >= default_threshold);
    // serration end: sync goes inactive
    wire serr_fall = sync_d_r && !sync_active;

    //////////////////////////////////////////////////////////////////////////
    // latch set/reset
    wire div_done = osc_bus.tick && (div_r == DIV_WIDTH'(OSC_CYCLES - 1));
    wire latch_set = capture_r || above_dflt;
    wire in_pulse = is_pulse(state_r);

    // set/reset latch as two states; sets are ignored while in pulse
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (latch_set) begin
                    state_nxt = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (div_done) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // divide-by-eight of oscillator ticks, cleared while idle
    assign div_nxt = !in_pulse ? '0 :
        (osc_bus.tick ? div_r + 1'b1 : div_r);

    assign osc_bus.run = in_pulse;

    vsync_osc #(
        .HALF_PERIOD(OSC_HALF)
    ) u_osc (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .port(osc_bus.osc)
    );

    //////////////////////////////////////////////////////////////////////////
    // registered next values
    assign sync_d_nxt = sync_active;
    assign capture_nxt = serr_fall && above_serr;
    assign csync_nxt = below_black;
    assign vsync_nxt = is_pulse(state_nxt);
    assign vsync_d_nxt = vsync_r;
    assign field_clk_nxt = vsync_r && !vsync_d_r;

    //////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            integ_r <= INTEG_RESET;
        end else begin
            integ_r <= integ_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sync_d_r <= 1'b0;
        end else begin
            sync_d_r <= sync_d_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            capture_r <= 1'b0;
        end else begin
            capture_r <= capture_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            div_r <= '0;
        end else begin
            div_r <= div_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            csync_r <= 1'b0;
        end else begin
            csync_r <= csync_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            vsync_r <= 1'b0;
        end else begin
            vsync_r <= vsync_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            vsync_d_r <= 1'b0;
        end else begin
            vsync_d_r <= vsync_d_nxt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            field_clk_r <= 1'b0;
        end else begin
            field_clk_r <= field_clk_nxt;
        end
    end

    // outputs come straight from flip-flops
    assign csync_out = csync_r;
    assign vsync_out = vsync_r;
    assign field_clk_out = field_clk_r;
endmodule : vsync_extractor

// [testbench/video_src.sv]
`timescale 1ns/1ps
module video_src (
    // clock and sliced sync
    input wire logic clk_sys,
    output logic below_black
);
    initial below_black = 1'b0;
    // sync active for hi clocks, then idle for lo clocks, driven on the falling edge
    task automatic pulse(input int hi, input int lo);
        repeat (hi) begin
            @(negedge clk_sys) below_black = 1'b1;
        end
        repeat (lo) begin
            @(negedge clk_sys) below_black = 1'b0;
        end
    endtask : pulse
endmodule : video_src

// [testbench/vsync_extractor_asserts.sv]
`timescale 1ns/1ps
module vsync_extractor_asserts
    import vsync_pkg::*;
#(
    parameter int OSC_HALF = OSC_HALF_DEFAULT
) (
    // watched ports
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic below_black,
    input wire logic csync_out,
    input wire logic vsync_out,
    input wire logic field_clk_out
);
    logic [15:0] width_r;
    always_ff @(posedge clk_sys) width_r <= vsync_out ? width_r + 16'h0001 : 16'h0000;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence field_strobe;
        field_clk_out ##1 !field_clk_out;
    endsequence
    a_csync_copy: assert property ($past(nrst) |-> csync_out == $past(below_black))
        else $error("csync not a delayed copy");
    a_quiet_reset: assert property (disable iff (1'b0) !nrst |=> !vsync_out && !field_clk_out)
        else $error("outputs active after reset");
    a_field_strobe: assert property ($rose(vsync_out) |=> field_strobe)
        else $error("field clock missing");
    a_field_only: assert property ($rose(field_clk_out) |-> $past(vsync_out))
        else $error("field clock without vsync");
    a_pulse_hold: assert property ($rose(vsync_out) |=> vsync_out [*8])
        else $error("vsync pulse too short");
    a_pulse_width: assert property ($fell(vsync_out) |->
        width_r inside {[16 * OSC_HALF - 1 : 16 * OSC_HALF + 2]})
        else $error("vsync width wrong");
    a_pulse_cap: assert property (vsync_out |-> width_r <= 16 * OSC_HALF + 2)
        else $error("vsync held too long");
    a_rise_cause: assert property ($rose(vsync_out) |-> $past(below_black, 3))
        else $error("vsync rose without sync");
endmodule : vsync_extractor_asserts
bind vsync_extractor vsync_extractor_asserts #(.OSC_HALF(OSC_HALF)) chk (.clk_sys(clk_sys),
    .nrst(nrst), .below_black(below_black), .csync_out(csync_out),
    .vsync_out(vsync_out), .field_clk_out(field_clk_out));

// [testbench/vsync_extractor_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); end end
module vsync_extractor_tb;
    import vsync_pkg::*;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic below_black, csync_out, vsync_out, field_clk_out, prev_r = 1'b0;
    int error_cnt = 0, samples_checked = 0, rises = 0, base;
    initial forever #4 clk_sys = ~clk_sys;
    video_src src (.clk_sys(clk_sys), .below_black(below_black));
    vsync_extractor #(.serration_threshold(16'h0014), .default_threshold(16'h003C),
        .DISCHARGE_STEP(16'h0008), .OSC_HALF(4)) uut (.clk_sys(clk_sys), .nrst(nrst),
        .below_black(below_black), .csync_out(csync_out), .vsync_out(vsync_out),
        .field_clk_out(field_clk_out));
    always @(posedge clk_sys) begin
        prev_r <= vsync_out;
        if (vsync_out === 1'b1 && prev_r === 1'b0) rises++;
    end
    // rises expected from one isolated pulse starting with an empty integrator
    function automatic int exp_rises(input int hi);
        return (hi > 20) ? 1 : 0;
    endfunction : exp_rises
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    task automatic one(input int hi, input int lo);
        base = rises;
        src.pulse(hi, lo);
        `CHK(rises - base, exp_rises(hi))
    endtask : one
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        print_verdict();
    end
    initial begin
        void'($urandom(54384));
        repeat (8) @(negedge clk_sys);
        nrst = 1'b1;
        base = rises;
        repeat (20) src.pulse(2 + $urandom % 7, 30);
        `CHK(rises - base, 0)
        one(15, 100);
        one(15 + $urandom % 5, 100);
        one(20, 100);
        one(21, 100);
        repeat (3) one(25 + $urandom % 10, 120);
        base = rises;
        src.pulse(90, 150);
        `CHK(rises - base, 1)
        base = rises;
        repeat (6) src.pulse(26, 4);
        src.pulse(0, 150);
        `CHK(rises - base, 2)
        base = rises;
        repeat (2) src.pulse(26, 4);
        src.pulse(0, 150);
        `CHK(rises - base, 1)
        print_verdict();
    end
endmodule : vsync_extractor_tb
